// file: logic/rsd_map.vh
// constants of the remote setting decoder
`ifndef RSD_MAP_VH
`define RSD_MAP_VH
// ****************************************
// status byte bit positions
// ****************************************
`define RSD_SB_RQS 6
`define RSD_SB_ERR 5
`define RSD_SB_KEY 2
`define RSD_SB_OUT 0
// ****************************************
// characters (7-bit ascii, upper case)
// ****************************************
`define RSD_CH_TAB 7'h09
`define RSD_CH_LF 7'h0A
`define RSD_CH_CR 7'h0D
`define RSD_CH_SP 7'h20
`define RSD_CH_PLUS 7'h2B
`define RSD_CH_MINUS 7'h2D
`define RSD_CH_ZERO 7'h30
`define RSD_CH_NINE 7'h39
`define RSD_CH_SEMI 7'h3B
`define RSD_CASE_MASK 7'h5F
`define RSD_HD_AMP 7'h41
`define RSD_HD_MARK 7'h43
`define RSD_HD_OFS 7'h44
`define RSD_HD_FREQ 7'h46
`define RSD_HD_MASK 7'h4B
`define RSD_HD_MODE 7'h4D
`define RSD_HD_OUT 7'h4F
`define RSD_HD_PHASE 7'h50
`define RSD_HD_SPACE 7'h53
`define RSD_HD_TRIG 7'h54
`define RSD_HD_DUTY 7'h56
`define RSD_HD_WAVE 7'h57
// ****************************************
// limits and digit counts
// ****************************************
`define RSD_BUF_DEPTH 14
`define RSD_DIG_FREQ 4'hB
`define RSD_DIG_PHASE 4'h4
`define RSD_DIG_OTHER 4'h2
`define RSD_FREQ_MAX 37'h2_540B_E400
`define RSD_PHASE_MAX 37'h0_0000_0E10
`define RSD_CYC_MAX 37'h0_0000_0010
// ****************************************
// reset values of the settings
// ****************************************
`define RSD_RST_FREQ 34'h0_0098_9680
`define RSD_RST_CYC 5'h01
`define RSD_RST_MASK 8'h00
// ****************************************
// execution times in tenths of a ms
// ****************************************
`define RSD_CLK_MHZ 200
`define RSD_TICK_US 100
`define RSD_TICK_CYCLES (`RSD_TICK_US * `RSD_CLK_MHZ)
`define RSD_T_AMP 7'h38
`define RSD_T_MARK 7'h39
`define RSD_T_OFS 7'h17
`define RSD_T_FREQ 7'h37
`define RSD_T_MASK 7'h14
`define RSD_T_MODE 7'h1E
`define RSD_T_OUT 7'h3A
`define RSD_T_PHASE 7'h3E
`define RSD_T_SPACE 7'h3A
`define RSD_T_TRIG 7'h14
`define RSD_T_DUTY 7'h18
`define RSD_T_WAVE 7'h40
`endif

// file: logic/rsd_fifo.v
// receive fifo between the bus acceptor and the command buffer
`timescale 1ns/10ps
`default_nettype none
module rsd_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_i,                 // system clock
    input wire rst_i,                 // synchronous reset
    input wire flush_i,               // drop all stored words
    input wire in_valid_i,            // word offered
    output reg in_ready_o,            // room for a word
    input wire [WIDTH-1:0] in_data_i, // word in
    output wire out_valid_o,          // word available
    input wire out_ready_i,           // consumer takes word
    output wire [WIDTH-1:0] out_data_o // word out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage
    reg [AW-1:0] wp_q;                 // write pointer
    reg [AW-1:0] rp_q;                 // read pointer
    reg [AW:0] cnt_q;                  // fill level
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = mem_q[rp_q];
    // ****************************************
    // pointers, level and registered ready
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data_i;
                wp_q <= (wp_q == DEPTH - 1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == DEPTH - 1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            // honest full: ready drops when the last slot fills
            in_ready_o <= (cnt_d != DEPTH);
        end
    end
endmodule
`default_nettype wire

// file: logic/rsd_decoder.v
// remote setting decoder: command buffer, parser, status byte
`timescale 1ns/10ps
`default_nettype none
`include "rsd_map.vh"
module rsd_decoder #(
    parameter TICK_CYCLES = `RSD_TICK_CYCLES, // clocks per 0.1 ms
    parameter FIFO_DEPTH = 16,                // receive fifo words
    parameter FIFO_AW = 4                     // fifo pointer width
) (
    input wire CLK_I,                // 200 MHz clock
    input wire SYS_RST_I,            // synchronous reset, high
    input wire [7:0] RX_DATA_I,      // received bus byte
    input wire RX_EOI_I,             // end marker with byte
    input wire RX_VALID_I,           // byte offered
    output wire RX_READY_O,          // byte can be taken
    input wire DEV_CLR_I,            // device clear pulse
    input wire SPOLL_RD_I,           // status byte read pulse
    input wire OUT_KEY_I,            // output key pressed pulse
    output reg [7:0] STATUS_BYTE_O,  // serial poll status byte
    output reg SRQ_O,                // service request, high
    output reg [1:0] AMP_RANGE_O,    // amplitude range code
    output reg [4:0] MARK_CYCLES_O,  // burst on cycles
    output reg OFFSET_ON_O,          // dc offset enabled
    output reg [33:0] FREQ_O,        // frequency, 0.1 mHz units
    output reg [2:0] MODE_O,         // oscillation mode
    output reg OUTPUT_ON_O,          // output switched on
    output reg [12:0] PHASE_O,       // phase, 0.1 degree, signed
    output reg [4:0] SPACE_CYCLES_O, // burst gap cycles
    output reg TRIG_O,               // bus trigger level
    output reg DUTY_VAR_O,           // variable duty enabled
    output reg [2:0] WAVE_O,         // waveform code
    output reg BUSY_O                // string being executed
);
    // ****************************************
    // states and declarations
    // ****************************************
    localparam [2:0] S_COLLECT = 3'h0; // filling the buffer
    localparam [2:0] S_HEAD = 3'h1;    // expecting a header
    localparam [2:0] S_NUM = 3'h2;     // gathering digits
    localparam [2:0] S_APPLY = 3'h3;   // checking and storing
    localparam [2:0] S_WAIT = 3'h4;    // execution time
    localparam [19:0] TICK_LD = TICK_CYCLES - 1; // tick reload

    reg [2:0] state_q;         // parser state
    reg [6:0] buf_q [0:13];    // command character buffer
    reg [3:0] cnt_q;           // characters held
    reg [3:0] idx_q;           // parse position
    reg disc_q;                // discarding after overflow
    reg [6:0] hdr_q;           // current header letter
    reg neg_q;                 // minus sign seen
    reg [3:0] ndig_q;          // digits gathered
    reg [36:0] acc_q;          // parameter value
    reg [19:0] tick_q;         // cycles within one tick
    reg [6:0] tenth_q;         // ticks left
    reg err_evt_q;             // one-cycle error event
    reg [7:0] mask_q;          // request enable mask
    reg err_q;                 // error cause flag
    reg key_q;                 // output key cause flag
    reg rqs_q;                 // request pending flag

    wire [8:0] f_data;         // fifo word out
    wire f_valid;              // fifo word available
    wire f_pop = f_valid & (state_q == S_COLLECT);
    wire [6:0] r_ch = f_data[6:0]; // top data bit ignored
    wire r_eoi = f_data[8];
    wire [6:0] ch = buf_q[idx_q];
    wire [6:0] up = ch & `RSD_CASE_MASK;
    wire at_end = (idx_q == cnt_q);
    wire is_dig = (ch >= `RSD_CH_ZERO) && (ch <= `RSD_CH_NINE);
    wire [36:0] dig = {33'h0_0000_0000, ch[3:0]};
    wire [36:0] acc_x10 = {acc_q[33:0], 3'b000} + {acc_q[35:0], 1'b0};

    // ****************************************
    // receive fifo, stalls while executing
    // ****************************************
    rsd_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .flush_i(DEV_CLR_I),
        .in_valid_i(RX_VALID_I),
        .in_ready_o(RX_READY_O),
        .in_data_i({RX_EOI_I, RX_DATA_I}),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop),
        .out_data_o(f_data)
    );

    // ****************************************
    // received character classes
    // ****************************************
    wire r_skip = (r_ch == `RSD_CH_SP) || (r_ch == `RSD_CH_TAB) || (r_ch == `RSD_CH_SEMI);
    wire r_crlf = (r_ch == `RSD_CH_CR) || (r_ch == `RSD_CH_LF);
    wire r_delim = r_crlf | r_eoi;
    wire r_store = ~r_skip & ~r_crlf & ~disc_q;
    wire r_full = (cnt_q == `RSD_BUF_DEPTH);

    // ****************************************
    // header validity and digit limit
    // ****************************************
    reg hd_ok;        // known header
    reg [3:0] maxdig; // digits allowed for header
    always @* begin
        case (up)
            `RSD_HD_AMP, `RSD_HD_MARK, `RSD_HD_OFS, `RSD_HD_FREQ,
            `RSD_HD_MASK, `RSD_HD_MODE, `RSD_HD_OUT, `RSD_HD_PHASE,
            `RSD_HD_SPACE, `RSD_HD_TRIG, `RSD_HD_DUTY, `RSD_HD_WAVE: hd_ok = 1'b1;
            default: hd_ok = 1'b0;
        endcase
        case (hdr_q)
            `RSD_HD_FREQ: maxdig = `RSD_DIG_FREQ;
            `RSD_HD_PHASE: maxdig = `RSD_DIG_PHASE;
            default: maxdig = `RSD_DIG_OTHER;
        endcase
    end

    // ****************************************
    // range check and execution time
    // ****************************************
    reg ok_c;         // parameter in range
    reg [6:0] time_c; // execution ticks
    always @* begin
        ok_c = 1'b0;
        time_c = `RSD_T_MASK;
        case (hdr_q)
            `RSD_HD_AMP: begin
                ok_c = (acc_q <= 37'h0_0000_0003);
                time_c = `RSD_T_AMP;
            end
            `RSD_HD_MARK, `RSD_HD_SPACE: begin
                ok_c = (acc_q != 37'h0_0000_0000) && (acc_q <= `RSD_CYC_MAX);
                time_c = (hdr_q == `RSD_HD_MARK) ? `RSD_T_MARK : `RSD_T_SPACE;
            end
            `RSD_HD_OFS, `RSD_HD_OUT, `RSD_HD_TRIG, `RSD_HD_DUTY: begin
                ok_c = (acc_q <= 37'h0_0000_0001);
                case (hdr_q)
                    `RSD_HD_OFS: time_c = `RSD_T_OFS;
                    `RSD_HD_OUT: time_c = `RSD_T_OUT;
                    `RSD_HD_TRIG: time_c = `RSD_T_TRIG;
                    default: time_c = `RSD_T_DUTY;
                endcase
            end
            `RSD_HD_FREQ: begin
                ok_c = (acc_q != 37'h0_0000_0000) && (acc_q <= `RSD_FREQ_MAX);
                time_c = `RSD_T_FREQ;
            end
            `RSD_HD_MASK: begin
                ok_c = (acc_q == 37'h0_0000_0000) || (acc_q == 37'h0_0000_0004) ||
                       (acc_q == 37'h0_0000_0020) || (acc_q == 37'h0_0000_0024);
                time_c = `RSD_T_MASK;
            end
            `RSD_HD_MODE, `RSD_HD_WAVE: begin
                ok_c = (acc_q <= 37'h0_0000_0004);
                time_c = (hdr_q == `RSD_HD_MODE) ? `RSD_T_MODE : `RSD_T_WAVE;
            end
            `RSD_HD_PHASE: begin
                ok_c = (acc_q <= `RSD_PHASE_MAX);
                time_c = `RSD_T_PHASE;
            end
            default: begin
                ok_c = 1'b0;
            end
        endcase
        if (ndig_q == 4'h0) begin
            ok_c = 1'b0;
        end
    end

    // ****************************************
    // buffer, parser and settings
    // ****************************************
    always @(posedge CLK_I) begin
        err_evt_q <= 1'b0;
        if (SYS_RST_I) begin
            state_q <= S_COLLECT;
            cnt_q <= 4'h0;
            idx_q <= 4'h0;
            disc_q <= 1'b0;
            hdr_q <= 7'h00;
            neg_q <= 1'b0;
            ndig_q <= 4'h0;
            acc_q <= 37'h0_0000_0000;
            tick_q <= 20'h0_0000;
            tenth_q <= 7'h00;
            BUSY_O <= 1'b0;
            AMP_RANGE_O <= 2'h0;
            MARK_CYCLES_O <= `RSD_RST_CYC;
            OFFSET_ON_O <= 1'b0;
            FREQ_O <= `RSD_RST_FREQ;
            MODE_O <= 3'h0;
            OUTPUT_ON_O <= 1'b0;
            PHASE_O <= 13'h0000;
            SPACE_CYCLES_O <= `RSD_RST_CYC;
            TRIG_O <= 1'b0;
            DUTY_VAR_O <= 1'b0;
            WAVE_O <= 3'h0;
            mask_q <= `RSD_RST_MASK;
        end else if (DEV_CLR_I) begin
            // device clear empties the buffer, keeps settings
            state_q <= S_COLLECT;
            cnt_q <= 4'h0;
            idx_q <= 4'h0;
            disc_q <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            // output key toggles the output
            if (OUT_KEY_I) begin
                OUTPUT_ON_O <= ~OUTPUT_ON_O;
            end
            case (state_q)
                S_COLLECT: begin
                    if (f_pop) begin
                        if (r_store && r_full) begin
                            cnt_q <= 4'h0;
                            disc_q <= ~r_delim;
                        end else if (r_store) begin
                            buf_q[cnt_q] <= r_ch;
                            cnt_q <= cnt_q + 4'h1;
                        end
                        if (r_delim) begin
                            disc_q <= 1'b0;
                            idx_q <= 4'h0;
                            if (!(r_store && r_full) && (cnt_q != 4'h0 || r_store)) begin
                                state_q <= S_HEAD;
                                BUSY_O <= 1'b1;
                            end
                        end
                    end
                end
                S_HEAD: begin
                    if (at_end) begin
                        cnt_q <= 4'h0;
                        state_q <= S_COLLECT;
                        BUSY_O <= 1'b0;
                    end else if (hd_ok) begin
                        hdr_q <= up;
                        idx_q <= idx_q + 4'h1;
                        neg_q <= 1'b0;
                        ndig_q <= 4'h0;
                        acc_q <= 37'h0_0000_0000;
                        state_q <= S_NUM;
                    end else begin
                        err_evt_q <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= S_COLLECT;
                        BUSY_O <= 1'b0;
                    end
                end
                S_NUM: begin
                    if (!at_end && ndig_q == 4'h0 && hdr_q == `RSD_HD_PHASE &&
                        (ch == `RSD_CH_PLUS || ch == `RSD_CH_MINUS) && !neg_q) begin
                        neg_q <= (ch == `RSD_CH_MINUS);
                        idx_q <= idx_q + 4'h1;
                    end else if (!at_end && is_dig) begin
                        if (ndig_q == maxdig) begin
                            err_evt_q <= 1'b1;
                            cnt_q <= 4'h0;
                            state_q <= S_COLLECT;
                            BUSY_O <= 1'b0;
                        end else begin
                            acc_q <= acc_x10 + dig;
                            ndig_q <= ndig_q + 4'h1;
                            idx_q <= idx_q + 4'h1;
                        end
                    end else begin
                        state_q <= S_APPLY;
                    end
                end
                S_APPLY: begin
                    if (!ok_c) begin
                        // out of range skips the rest
                        err_evt_q <= 1'b1;
                        cnt_q <= 4'h0;
                        state_q <= S_COLLECT;
                        BUSY_O <= 1'b0;
                    end else begin
                        case (hdr_q)
                            `RSD_HD_AMP: AMP_RANGE_O <= acc_q[1:0];
                            `RSD_HD_MARK: MARK_CYCLES_O <= acc_q[4:0];
                            `RSD_HD_OFS: OFFSET_ON_O <= acc_q[0];
                            `RSD_HD_FREQ: FREQ_O <= acc_q[33:0];
                            `RSD_HD_MASK: mask_q <= acc_q[7:0];
                            `RSD_HD_MODE: MODE_O <= acc_q[2:0];
                            `RSD_HD_OUT: OUTPUT_ON_O <= acc_q[0];
                            `RSD_HD_PHASE: PHASE_O <= neg_q ? (13'h0000 - acc_q[12:0]) : acc_q[12:0];
                            `RSD_HD_SPACE: SPACE_CYCLES_O <= acc_q[4:0];
                            `RSD_HD_TRIG: TRIG_O <= acc_q[0];
                            `RSD_HD_DUTY: DUTY_VAR_O <= acc_q[0];
                            `RSD_HD_WAVE: WAVE_O <= acc_q[2:0];
                            default: TRIG_O <= TRIG_O;
                        endcase
                        tick_q <= TICK_LD;
                        tenth_q <= time_c;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (tick_q != 20'h0_0000) begin
                        tick_q <= tick_q - 20'h0_0001;
                    end else if (tenth_q <= 7'h01) begin
                        state_q <= S_HEAD;
                    end else begin
                        tick_q <= TICK_LD;
                        tenth_q <= tenth_q - 7'h01;
                    end
                end
                default: begin
                    state_q <= S_COLLECT;
                    cnt_q <= 4'h0;
                    BUSY_O <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // status causes and service request
    // ****************************************
    wire poll_clr = SPOLL_RD_I & rqs_q; // read after request
    reg err_d;
    reg key_d;
    reg rqs_d;
    always @* begin
        // error cause, new event wins over clear
        err_d = (err_q & ~poll_clr & ~DEV_CLR_I) | err_evt_q;
        key_d = (key_q & ~poll_clr & ~DEV_CLR_I) | OUT_KEY_I;
        // request drops when read, cleared or masked
        rqs_d = (err_d & mask_q[`RSD_SB_ERR]) | (key_d & mask_q[`RSD_SB_KEY]);
    end

    always @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            err_q <= 1'b0;
            key_q <= 1'b0;
            rqs_q <= 1'b0;
            SRQ_O <= 1'b0;
            STATUS_BYTE_O <= 8'h00;
        end else begin
            err_q <= err_d;
            key_q <= key_d;
            rqs_q <= rqs_d;
            SRQ_O <= rqs_d;
            // bit 0 mirrors the output state
            STATUS_BYTE_O <= {1'b0, rqs_d, err_d, 2'b00, key_d, 1'b0, OUTPUT_ON_O};
        end
    end
endmodule
`default_nettype wire

// file: verification/rsd_decoder_assertions.sv
// port assertions for the remote setting decoder
`timescale 1ns/10ps
`default_nettype none
module rsd_decoder_assertions (
    input wire logic CLK_I, // clock
    input wire logic SYS_RST_I, // reset
    input wire logic DEV_CLR_I, // device clear
    input wire logic SPOLL_RD_I, // poll read
    input wire logic OUT_KEY_I, // output key
    input wire logic [7:0] STATUS_BYTE_O, // status byte
    input wire logic SRQ_O, // request line
    input wire logic OUTPUT_ON_O, // output state
    input wire logic [2:0] WAVE_O, // waveform
    input wire logic [2:0] MODE_O, // mode
    input wire logic BUSY_O // executing
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    property p_zero; {STATUS_BYTE_O[7], STATUS_BYTE_O[4:3], STATUS_BYTE_O[1]} == 4'h0; endproperty
    a_zero: assert property (p_zero) else $error("unused status bits set");
    property p_srq; SRQ_O == STATUS_BYTE_O[6]; endproperty
    a_srq: assert property (p_srq) else $error("request line differs from bit 6");
    property p_rqs; STATUS_BYTE_O[6] |-> STATUS_BYTE_O[5] || STATUS_BYTE_O[2]; endproperty
    a_rqs: assert property (p_rqs) else $error("request without cause");
    property p_out; STATUS_BYTE_O[0] == $past(OUTPUT_ON_O); endproperty
    a_out: assert property (p_out) else $error("bit 0 not following output");
    property p_key; OUT_KEY_I |=> STATUS_BYTE_O[2]; endproperty
    a_key: assert property (p_key) else $error("key bit not set");
    property p_tog; OUT_KEY_I && !BUSY_O |=> OUTPUT_ON_O != $past(OUTPUT_ON_O); endproperty
    a_tog: assert property (p_tog) else $error("output not toggled by key");
    property p_clr; DEV_CLR_I && !OUT_KEY_I |=> STATUS_BYTE_O[6:5] == 2'h0 && !STATUS_BYTE_O[2]; endproperty
    a_clr: assert property (p_clr) else $error("clear left status bits");
    property p_poll; SPOLL_RD_I && STATUS_BYTE_O[6] && !OUT_KEY_I && !BUSY_O |=> STATUS_BYTE_O[6:5] == 2'h0; endproperty
    a_poll: assert property (p_poll) else $error("poll left request bits");
    property p_hold; !BUSY_O |=> $stable({WAVE_O, MODE_O}); endproperty
    a_hold: assert property (p_hold) else $error("setting moved while idle");
endmodule
`default_nettype wire

// file: verification/rsd_host_model.sv
// bus controller model that hands bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module rsd_host_model (
    input wire logic clk_i, // clock
    input wire logic ready_i, // byte taken
    input wire logic slow_i, // pace bytes
    output logic [7:0] data_o, // byte
    output logic eoi_o, // end marker
    output logic valid_o // byte offered
);
    logic [8:0] q[$]; // queued {eoi, byte}
    logic [3:0] gap_q = 4'h0; // pacing count
    initial begin
        valid_o = 1'b0;
        data_o = 8'h00;
        eoi_o = 1'b0;
    end
    // slow pacing; request held until taken, idle lines keep changing
    always @(posedge clk_i) begin
        if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            {eoi_o, data_o} <= ~{eoi_o, data_o};
            gap_q <= slow_i ? 4'hF : 4'h0;
        end else if (!valid_o && gap_q == 4'h0 && q.size() != 0) begin
            valid_o <= 1'b1;
            {eoi_o, data_o} <= q.pop_front();
        end else if (!valid_o) begin
            data_o <= ~data_o;
            gap_q <= (gap_q == 4'h0) ? 4'h0 : gap_q - 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: verification/rsd_decoder_tb_top.sv
// testbench top for the remote setting decoder
`timescale 1ns/10ps
`default_nettype none
module rsd_decoder_tb_top;
    logic clk = 1'b0, rst = 1'b1, key = 1'b0, spoll = 1'b0, dev_clr = 1'b0, slow = 1'b0;
    logic rready, reoi, rvalid, srq, ofs, outon, trig, duty, busy;
    logic [7:0] rdata, status;
    logic [1:0] amp;
    logic [4:0] mark, space;
    logic [2:0] mode, wave;
    logic [33:0] freq;
    logic [12:0] phase;
    int num_errors = 0, check_count = 0, low_n = 0, busy_n = 0;
    initial forever #2.5 clk = ~clk;
    rsd_host_model host_u (.clk_i(clk), .ready_i(rready), .slow_i(slow), .data_o(rdata), .eoi_o(reoi), .valid_o(rvalid));
    rsd_decoder #(.TICK_CYCLES(2), .FIFO_DEPTH(16), .FIFO_AW(4)) dut_u (.CLK_I(clk), .SYS_RST_I(rst),
        .RX_DATA_I(rdata), .RX_EOI_I(reoi), .RX_VALID_I(rvalid), .RX_READY_O(rready), .DEV_CLR_I(dev_clr),
        .SPOLL_RD_I(spoll), .OUT_KEY_I(key), .STATUS_BYTE_O(status), .SRQ_O(srq), .AMP_RANGE_O(amp),
        .MARK_CYCLES_O(mark), .OFFSET_ON_O(ofs), .FREQ_O(freq), .MODE_O(mode), .OUTPUT_ON_O(outon),
        .PHASE_O(phase), .SPACE_CYCLES_O(space), .TRIG_O(trig), .DUTY_VAR_O(duty), .WAVE_O(wave), .BUSY_O(busy));
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle pulse: 0 key, 1 poll, 2 clear
    task automatic pulse(input int w);
        @(posedge clk);
        {key, spoll, dev_clr} <= 3'b100 >> w;
        @(posedge clk);
        {key, spoll, dev_clr} <= 3'b000;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // queue a string, close with carriage return or end marker, wait until executed
    // quiet window outlasts a full fifo draining before the busy flag rises
    task automatic send(input string s, input logic eoi_end);
        int n;
        int quiet;
        for (int i = 0; i < s.len(); i++) host_u.q.push_back({eoi_end && i == s.len() - 1, s[i]});
        if (!eoi_end) host_u.q.push_back(9'h00D);
        n = 0;
        quiet = 0;
        busy_n = 0;
        while (quiet < 24 && n < 3000) begin
            @(posedge clk);
            low_n += !rready;
            busy_n += busy;
            quiet = (rvalid || host_u.q.size() != 0 || busy) ? 0 : quiet + 1;
            n++;
        end
        if (n == 3000) begin
            num_errors++;
            summarize();
        end
        #1;
    endtask
    task automatic t_status();
        pulse(0);
        chk("status", status, 8'h05);
        chk("srq", srq, 1'b0);
        pulse(1);
        chk("status", status, 8'h05);
        pulse(2);
        chk("status", status, 8'h01);
        $display("status test done");
    endtask
    task automatic t_cmds();
        for (int i = 0; i < 5; i++) begin
            send($sformatf("m%0dW%0dA%0d", i, i, i % 4), 1'b0);
            chk("mode", mode, i);
            chk("wave", wave, i);
            chk("amp", amp, i % 4);
        end
        send("C16S16D1V1O1T1", 1'b1);
        chk("mark", mark, 16);
        chk("space", space, 16);
        chk("trig", trig, 1);
        chk("switches", {ofs, duty, outon}, 3'h7);
        send("T0;D0 V0O0", 1'b0);
        chk("flags", {trig, ofs, duty, outon}, 0);
        send("F10000000000", 1'b0);
        chk("freq", freq, 34'h2_540B_E400);
        send("P-3600", 1'b0);
        chk("phase", phase, 13'h1_1F0);
        send("P3600", 1'b0);
        chk("phase", phase, 13'h0_E10);
        $display("command test done");
    endtask
    task automatic t_err();
        slow <= 1'b1;
        send("K32A1A9A2", 1'b0);
        chk("amp", amp, 1);
        chk("status", status, 8'h60);
        chk("srq", srq, 1'b1);
        pulse(1);
        chk("status", status, 8'h00);
        send("K4", 1'b0);
        pulse(0);
        chk("status", status, 8'h45);
        send("K0", 1'b0);
        // mask code takes 20 ticks of 2 clocks, plus a few parse steps
        chk("exec", busy_n >= 40 && busy_n <= 48, 1'b1);
        chk("status", status, 8'h05);
        send("K5", 1'b0);
        chk("status", status, 8'h25);
        pulse(2);
        chk("status", status, 8'h01);
        slow <= 1'b0;
        $display("error test done");
    endtask
    task automatic t_buf();
        low_n = 0;
        send("W1W1W1W1W1W1W1W", 1'b0);
        chk("wave", wave, 4);
        chk("status", status, 8'h01);
        send({"W3\n", {20{" "}}, "m2"}, 1'b0);
        chk("full", low_n != 0, 1'b1);
        chk("mode", {wave, mode}, 6'h1A);
        $display("buffer test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_status();
        t_cmds();
        t_err();
        t_buf();
        summarize();
    end
endmodule
bind rsd_decoder rsd_decoder_assertions chk_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .DEV_CLR_I(DEV_CLR_I),
    .SPOLL_RD_I(SPOLL_RD_I), .OUT_KEY_I(OUT_KEY_I), .STATUS_BYTE_O(STATUS_BYTE_O), .SRQ_O(SRQ_O),
    .OUTPUT_ON_O(OUTPUT_ON_O), .WAVE_O(WAVE_O), .MODE_O(MODE_O), .BUSY_O(BUSY_O));
`default_nettype wire
